// >>> hw/transceiver_host_port.sv
// host access port: parallel bus styles, serial mode, interrupt pin
`timescale 1ns/1ps
`include "host_port_consts.svh"
// Operation
// R01: interrupt pin pulled low on an enabled status change.
// R02: interrupt is active low open drain, each source maskable.
// R03: host treats the interrupt as a level, not an edge.
// R04: strobe style read: acknowledge low marks returned data valid.
// R05: strobe style write: acknowledge low once the register took data.
// R06: strobe style: wait states only for a write right after an access.
// R07: enable style: ready high when the access has finished.
// R08: enable style: ready low while the transfer is in progress.
// R09: enable style: ready released to high impedance after the cycle.
// R10: serial out valid on rising edge if edge select high, else falling.
// R11: serial out stays high impedance for a whole serial write.
// R12: latch enable style: address taken on latch enable falling edge.
// R13: host uses shared address pin as active low address strobe.
// R14: host drives shared strobe pin as data strobe or write enable.
// R15: host drives direction pin as read/write or read enable.
// R16: host sends command, address, write data on serial in.
// R17: host supplies the serial shift clock on the latch pin.
// R18: host takes chip select low for each whole access.
// R19: bus style select low gives strobe style, high gives enable style.
module transceiver_host_port (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic serial_mode_i,
	input wire logic bus_style_sel_i,
	input wire logic output_edge_sel_i,
	input wire logic cs_n_i,
	input wire logic ale_sclk_i,
	input wire logic data_strobe_i,
	input wire logic rw_rd_i,
	input wire logic [7:0] ad_i,
	output logic [7:0] ad_o,
	output logic ad_oe_o,
	output logic ack_rdy_o,
	output logic ack_rdy_oe_o,
	output logic int_n_o,
	output logic int_n_oe_o,
	input wire logic [7:0] status_i
);
	localparam int NPINS = 15;

	logic [NPINS-1:0] pins;
	logic [NPINS-1:0] sync1;
	logic [NPINS-1:0] sync2;
	host_port_pkg::par_state_t state;
	host_port_pkg::par_state_t next_state;
	logic ale_prev;
	host_port_pkg::byte_t addr_q;
	host_port_pkg::byte_t dout;
	host_port_pkg::byte_t ier;
	host_port_pkg::byte_t pending;
	host_port_pkg::byte_t status_prev;
	host_port_pkg::byte_t sp_q;
	logic sp_sel;
	logic rd_cycle;
	logic [3:0] rec_cnt;
	logic par_issue;
	logic ser_out;
	logic ser_oe;
	logic [7:0] mem_rdata;

	reg_access_if acc ();

	function automatic logic in_mem(input host_port_pkg::byte_t a);
		in_mem = (a < 8'(`HP_MEM_DEPTH));
	endfunction

	function automatic host_port_pkg::byte_t special_rd(
		input host_port_pkg::byte_t a,
		input host_port_pkg::byte_t ie,
		input host_port_pkg::byte_t pend,
		input host_port_pkg::byte_t stat);
		special_rd = 8'h00;
		if (a == `HP_ADDR_IER) begin
			special_rd = ie;
		end else if (a == `HP_ADDR_ISR) begin
			special_rd = pend;
		end else if (a == `HP_ADDR_STAT) begin
			special_rd = stat;
		end
	endfunction

	// every pin is asynchronous to mclk
	assign pins = {serial_mode_i, bus_style_sel_i, output_edge_sel_i,
		cs_n_i, ale_sclk_i, data_strobe_i, rw_rd_i, ad_i};

	generate
		for (genvar g = 0; g < NPINS; g++) begin : g_sync
			always_ff @(posedge mclk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					sync1[g] <= 1'b1;
					sync2[g] <= 1'b1;
				end else begin
					sync1[g] <= pins[g];
					sync2[g] <= sync1[g];
				end
			end
		end
	endgenerate

	wire serial_s = sync2[14];
	wire style_s = sync2[13];
	wire edge_s = sync2[12];
	wire cs_n_s = sync2[11];
	wire ale_s = sync2[10];
	wire dstb_s = sync2[9];
	wire rw_s = sync2[8];
	wire [7:0] ad_s = sync2[7:0];

	wire moto = ~style_s; // [R19]
	wire ale_fall = ale_prev & ~ale_s;
	wire par_strobe = moto ? ~dstb_s : (~dstb_s | ~rw_s);
	wire par_read = moto ? rw_s : ~rw_s;
	wire start = ~serial_s & ~cs_n_s & par_strobe;
	wire released = cs_n_s | ~par_strobe;
	// back to back write must let the previous access settle
	wire need_wait = moto & ~par_read & (rec_cnt != 4'h0); // [R06]

	wire acc_re = serial_s ? acc.re : par_issue & par_read;
	wire acc_we = serial_s ? acc.we : par_issue & ~par_read;
	wire [7:0] acc_addr = serial_s ? acc.addr : addr_q;
	wire [7:0] acc_wdata = serial_s ? acc.wdata : ad_s;
	wire isr_clr = acc_re & (acc_addr == `HP_ADDR_ISR);
	wire [7:0] change = status_i ^ status_prev;
	wire int_req = |(pending & ier); // [R01]

	assign acc.rdata = sp_sel ? sp_q : mem_rdata;

	always_comb begin
		next_state = state;
		par_issue = 1'b0;
		unique case (state)
			host_port_pkg::P_IDLE: begin
				if (start) begin
					if (need_wait) begin
						next_state = host_port_pkg::P_WAIT; // [R06]
					end else begin
						par_issue = 1'b1;
						next_state = host_port_pkg::P_RUN;
					end
				end
			end
			host_port_pkg::P_WAIT: begin
				if (released) begin
					next_state = host_port_pkg::P_IDLE;
				end else if (rec_cnt == 4'h0) begin
					par_issue = 1'b1;
					next_state = host_port_pkg::P_RUN;
				end
			end
			host_port_pkg::P_RUN: begin
				next_state = host_port_pkg::P_HOLD;
			end
			host_port_pkg::P_HOLD: begin
				if (released) begin
					next_state = host_port_pkg::P_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= host_port_pkg::P_IDLE;
			ale_prev <= 1'b1;
			addr_q <= 8'h00;
			rd_cycle <= 1'b0;
			dout <= 8'h00;
		end else begin
			state <= next_state;
			ale_prev <= ale_s;
			if (!serial_s && ale_fall) begin
				addr_q <= ad_s; // [R12]
			end
			if (par_issue) begin
				rd_cycle <= par_read;
			end
			if (state == host_port_pkg::P_RUN) begin
				dout <= acc.rdata;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rec_cnt <= 4'h0;
		end else if (state == host_port_pkg::P_HOLD && released) begin
			rec_cnt <= 4'(`HP_RECOVERY_CYC); // [R06]
		end else if (rec_cnt != 4'h0) begin
			rec_cnt <= rec_cnt - 4'h1;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ier <= `HP_IER_RST;
			pending <= 8'h00;
			status_prev <= 8'h00;
			sp_q <= 8'h00;
			sp_sel <= 1'b0;
		end else begin
			status_prev <= status_i;
			// a change in the clearing cycle survives the clear
			pending <= (isr_clr ? 8'h00 : pending) | change; // [R01]
			if (acc_we && acc_addr == `HP_ADDR_IER) begin
				ier <= acc_wdata; // [R02]
			end
			if (acc_re) begin
				sp_sel <= ~in_mem(acc_addr);
				sp_q <= special_rd(acc_addr, ier, pending, status_i);
			end
		end
	end

	reg_mem u_mem (
		.mclk_i(mclk_i),
		.we_i(acc_we & in_mem(acc_addr)),
		.addr_i(acc_addr[3:0]),
		.wdata_i(acc_wdata),
		.rdata_o(mem_rdata)
	);

	serial_engine u_ser (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.enable_i(serial_s),
		.cs_n_i(cs_n_s),
		.sclk_i(ale_s),
		.serial_in_i(dstb_s),
		.edge_sel_i(edge_s),
		.acc(acc.serial),
		.serial_out_o(ser_out),
		.serial_oe_o(ser_oe)
	);

	// open drain: only ever pulls low
	assign int_n_o = 1'b0; // [R02]
	assign int_n_oe_o = int_req; // [R01]
	assign ad_o = dout;
	assign ad_oe_o = ~serial_s & (state == host_port_pkg::P_HOLD) & rd_cycle;
	// strobe style: drive low as acknowledge; enable style: low busy, high done
	assign ack_rdy_o = serial_s ? ser_out :
		(moto ? 1'b0 : (state == host_port_pkg::P_HOLD)); // [R04] [R05] [R07]
	assign ack_rdy_oe_o = serial_s ? ser_oe :
		(moto ? (state == host_port_pkg::P_HOLD) :
		(state != host_port_pkg::P_IDLE)); // [R08] [R09]

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_idle_start;
		state == host_port_pkg::P_IDLE && start;
	endsequence
	sequence s_moto_read;
		s_idle_start and (moto && par_read);
	endsequence
	sequence s_moto_write_free;
		s_idle_start and (moto && !par_read && rec_cnt == 4'h0);
	endsequence
	sequence s_ack_low;
		ack_rdy_oe_o && !ack_rdy_o;
	endsequence

	AST_MOTO_RD: assert property (s_moto_read |-> ##2 (s_ack_low and
		ad_oe_o)) // [R04]
		else $error("read acknowledge or data not presented");
	AST_MOTO_WR: assert property (s_moto_write_free |-> ##2 s_ack_low) // [R05]
		else $error("write acknowledge missing");
	AST_MOTO_WAIT: assert property (s_idle_start and (moto && !par_read &&
		rec_cnt != 4'h0) |=> !ack_rdy_oe_o [*2]) // [R06]
		else $error("write after access not held off");
	AST_RDY_BUSY: assert property (!serial_s && !moto &&
		state == host_port_pkg::P_RUN |-> s_ack_low) // [R08]
		else $error("ready not low during transfer");
	AST_RDY_DONE: assert property (!serial_s && !moto &&
		state == host_port_pkg::P_RUN |=> ack_rdy_oe_o && ack_rdy_o) // [R07]
		else $error("ready not high at completion");
	AST_RDY_REL: assert property (!serial_s && !moto &&
		state == host_port_pkg::P_HOLD && released |=>
		state == host_port_pkg::P_IDLE && !ack_rdy_oe_o) // [R09]
		else $error("ready not released after cycle");
	AST_INT_SET: assert property (|(change & ier) |=>
		int_n_oe_o && !int_n_o) // [R01]
		else $error("interrupt not raised on enabled change");
	AST_INT_MASK: assert property (change == 8'h00 &&
		(pending & ier) == 8'h00 |=> !int_n_oe_o) // [R02]
		else $error("masked interrupt reached the pin");
	AST_ALE: assert property (!serial_s && ale_fall |=>
		addr_q == $past(ad_s)) // [R12]
		else $error("address not latched on latch enable fall");
endmodule

// >>> inc/host_port_consts.svh
// constants for the transceiver host access port
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH
`define HP_CLK_MHZ 200
`define HP_RECOVERY_NS 40
`define HP_RECOVERY_CYC ((`HP_RECOVERY_NS * `HP_CLK_MHZ + 999) / 1000)
`define HP_ADDR_IER 8'h10
`define HP_ADDR_ISR 8'h11
`define HP_ADDR_STAT 8'h12
`define HP_MEM_DEPTH 16
`define HP_IER_RST 8'h00
`define HP_RW_BIT 0
`define HP_ADDR_LSB 1
`define HP_ADDR_MSB 6
`define HP_CMD_BITS 8
`define HP_FRAME_BITS 16
`endif

// >>> inc/host_port_pkg.sv
// types shared by the host access port modules
package host_port_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {P_IDLE, P_WAIT, P_RUN, P_HOLD} par_state_t;
endpackage

// >>> inc/reg_access_if.sv
// register access path between the serial engine and the port core
`timescale 1ns/1ps
interface reg_access_if;
	logic re;
	logic we;
	host_port_pkg::byte_t addr;
	host_port_pkg::byte_t wdata;
	host_port_pkg::byte_t rdata;
	modport serial (output re, output we, output addr, output wdata,
		input rdata);
	modport core (input re, input we, input addr, input wdata,
		output rdata);
endinterface

// >>> hw/reg_mem.sv
// general register storage with registered read data
`timescale 1ns/1ps
`include "host_port_consts.svh"
module reg_mem (
	input wire logic mclk_i,
	input wire logic we_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:`HP_MEM_DEPTH-1];

	always_ff @(posedge mclk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		rdata_o <= mem[addr_i];
	end
endmodule

// >>> hw/serial_engine.sv
// serial host mode: command, address and data shifting
`timescale 1ns/1ps
`include "host_port_consts.svh"
module serial_engine (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic enable_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic serial_in_i,
	input wire logic edge_sel_i,
	reg_access_if.serial acc,
	output logic serial_out_o,
	output logic serial_oe_o
);
	logic sclk_prev;
	logic [3:0] cnt;
	logic [7:0] sh;
	logic [7:0] cmd;
	logic [7:0] rbyte;
	logic rd_phase;
	logic wr_phase;
	logic re_q;
	logic [2:0] oidx;
	logic sout;
	wire rise = sclk_i & ~sclk_prev;
	wire fall = ~sclk_i & sclk_prev;
	wire cap = enable_i & ~cs_n_i & rise;
	wire [7:0] shin = {serial_in_i, sh[7:1]};
	wire cmd_done = cap & (cnt == 4'(`HP_CMD_BITS - 1));
	wire data_done = cap & (cnt == 4'(`HP_FRAME_BITS - 1));
	// output changes on the edge opposite to the one it is valid on
	wire out_edge = edge_sel_i ? fall : rise; // [R10]

	assign acc.re = cmd_done & shin[`HP_RW_BIT];
	assign acc.we = data_done & wr_phase;
	assign acc.addr = cmd_done ?
		{2'b00, shin[`HP_ADDR_MSB:`HP_ADDR_LSB]} :
		{2'b00, cmd[`HP_ADDR_MSB:`HP_ADDR_LSB]};
	assign acc.wdata = shin;
	assign serial_out_o = sout;
	assign serial_oe_o = enable_i & ~cs_n_i & rd_phase; // [R11]

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sclk_prev <= 1'b1;
			cnt <= 4'h0;
			sh <= 8'h00;
			cmd <= 8'h00;
			rd_phase <= 1'b0;
			wr_phase <= 1'b0;
		end else begin
			sclk_prev <= sclk_i;
			if (cs_n_i | ~enable_i) begin
				cnt <= 4'h0;
				rd_phase <= 1'b0;
				wr_phase <= 1'b0;
			end else if (cap) begin
				sh <= shin;
				cnt <= cnt + 4'h1;
				if (cmd_done) begin
					cmd <= shin;
					rd_phase <= shin[`HP_RW_BIT];
					wr_phase <= ~shin[`HP_RW_BIT];
				end
				if (data_done) begin
					wr_phase <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			re_q <= 1'b0;
			rbyte <= 8'h00;
			oidx <= 3'h0;
			sout <= 1'b0;
		end else begin
			re_q <= acc.re;
			if (re_q) begin
				rbyte <= acc.rdata;
				// falling-valid case: first bit must be out before next fall
				if (!edge_sel_i) begin
					sout <= acc.rdata[0]; // [R10]
				end
				oidx <= edge_sel_i ? 3'h0 : 3'h1;
			end else if (rd_phase & out_edge) begin
				sout <= rbyte[oidx]; // [R10]
				oidx <= oidx + 3'h1;
			end
		end
	end

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	AST_SER_WR_HIZ: assert property (wr_phase |-> !serial_oe_o) // [R11]
		else $error("serial out driven during a write access");
	AST_SER_EDGE: assert property (
		rd_phase && !out_edge && !re_q |=> $stable(serial_out_o)) // [R10]
		else $error("serial out changed off its output edge");
endmodule

// >>> tb/host_model.sv
// host side model: parallel bus cycles and serial frames
`timescale 1ns/1ps
module host_model (
	input wire logic mclk_i,
	input wire logic [7:0] ad_i,
	input wire logic ad_oe_i,
	input wire logic ack_rdy_i,
	input wire logic ack_rdy_oe_i,
	output logic cs_n_o,
	output logic ale_sclk_o,
	output logic data_strobe_o,
	output logic rw_rd_o,
	output logic [7:0] bus_o
);
	initial begin
		cs_n_o = 1'b1;
		ale_sclk_o = 1'b0;
		data_strobe_o = 1'b1;
		rw_rd_o = 1'b1;
		bus_o = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	// st 0 strobe style, 1 enable style; lat counts edges to the answer
	task automatic par(input logic st, input logic wr, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q, output int lat,
		output logic lo, output logic rel);
		int i;
		lat = 0;
		lo = 1'b0;
		bus_o <= a;
		ale_sclk_o <= 1'b1;
		tick(2);
		ale_sclk_o <= 1'b0;
		tick(2);
		cs_n_o <= 1'b0;
		bus_o <= wr ? d : ~a;
		rw_rd_o <= st ? wr : ~wr;
		data_strobe_o <= st ? ~wr : 1'b0;
		for (i = 0; i < 40; i++) begin
			@(posedge mclk_i);
			lat++;
			if (ack_rdy_oe_i && ack_rdy_i === 1'b0) lo = 1'b1;
			if (ack_rdy_oe_i && ack_rdy_i === st) break;
		end
		q = ad_oe_i ? ad_i : 8'hxx;
		cs_n_o <= 1'b1;
		data_strobe_o <= 1'b1;
		rw_rd_o <= 1'b1;
		ale_sclk_o <= 1'b1;
		bus_o <= ~bus_o;
		for (i = 0; i < 20 && ack_rdy_oe_i; i++) @(posedge mclk_i);
		rel = !ack_rdy_oe_i;
	endtask
	// 16 bit frame, lsb first; sclk idles low outside frames
	task automatic ser(input logic wr, input logic es, input logic [5:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic oe);
		logic [15:0] f;
		f = {d, 1'b0, a, ~wr};
		q = 8'h00;
		oe = 1'b0;
		cs_n_o <= 1'b0;
		ale_sclk_o <= 1'b0;
		tick(10);
		for (int i = 0; i < 16; i++) begin
			data_strobe_o <= f[i];
			tick(10);
			ale_sclk_o <= 1'b1;
			oe |= ack_rdy_oe_i;
			if (i > 7 && es) q[i-8] = ack_rdy_i;
			tick(10);
			ale_sclk_o <= 1'b0;
			oe |= ack_rdy_oe_i;
			if (i > 6 && i < 15 && !es) q[i-7] = ack_rdy_i;
		end
		tick(10);
		cs_n_o <= 1'b1;
		data_strobe_o <= ~f[15];
		tick(10);
	endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the host access port
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic smode = 1'b0;
	logic style = 1'b0;
	logic esel = 1'b0;
	logic [7:0] status = 8'h00;
	logic cs_n, ale, dstb, rw, ad_oe, ack, ack_oe, irq_n, irq_oe;
	logic [7:0] bus, ad_out, ier, pend;
	logic [7:0] mem [16];
	int n_errors = 0;
	int cmp_count = 0;
	always #2.5 mclk = ~mclk;
	transceiver_host_port dut (.mclk_i(mclk), .reset_n_i(reset_n),
		.serial_mode_i(smode), .bus_style_sel_i(style),
		.output_edge_sel_i(esel), .cs_n_i(cs_n), .ale_sclk_i(ale),
		.data_strobe_i(dstb), .rw_rd_i(rw), .ad_i(bus), .ad_o(ad_out),
		.ad_oe_o(ad_oe), .ack_rdy_o(ack), .ack_rdy_oe_o(ack_oe),
		.int_n_o(irq_n), .int_n_oe_o(irq_oe), .status_i(status));
	host_model host (.mclk_i(mclk), .ad_i(ad_out), .ad_oe_i(ad_oe),
		.ack_rdy_i(ack), .ack_rdy_oe_i(ack_oe), .cs_n_o(cs_n),
		.ale_sclk_o(ale), .data_strobe_o(dstb), .rw_rd_o(rw), .bus_o(bus));
	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		if (a < 8'h10) return mem[a[3:0]];
		if (a == 8'h10) return ier;
		if (a == 8'h11) return pend;
		return (a == 8'h12) ? status : 8'h00;
	endfunction
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic set_st(input logic [7:0] v);
		pend |= status ^ v;
		status <= v;
	endtask
	task automatic acc(input logic wr, input logic [7:0] a,
		input logic [7:0] d, output int lat);
		logic [7:0] q;
		logic lo, rel;
		host.par(style, wr, a, d, q, lat, lo, rel);
		`CHK(lat < 40, 1'b1)
		if (lat >= 40) complete_run();
		`CHK(rel, 1'b1)
		if (style) `CHK(lo, 1'b1)
		if (!wr) `CHK(q, exp_rd(a))
		if (!wr && a == 8'h11) pend = 8'h00;
		if (wr && a < 8'h10) mem[a[3:0]] = d;
		if (wr && a == 8'h10) ier = d;
	endtask
	initial begin
		repeat (60000) @(posedge mclk);
		n_errors++;
		complete_run();
	end
	initial begin
		int lat, lat2, lat_r;
		logic [7:0] a, d, q;
		logic oe;
		void'($urandom(32'h01e0));
		ier = 8'h00;
		pend = 8'h00;
		repeat (4) @(posedge mclk);
		`CHK({ad_oe, ack_oe, irq_oe}, 3'b000)
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		for (int s = 0; s < 2; s++) begin
			style <= s[0];
			repeat (6) @(posedge mclk);
			acc(1'b0, 8'h10, 8'h00, lat);
			for (int k = 0; k < 10; k++) begin
				a = (k == 9) ? 8'h20 : 8'($urandom_range(0, 15));
				d = 8'($urandom);
				acc(1'b1, a, d, lat);
				acc(1'b0, a, 8'h00, lat);
			end
			$display("parallel style %0d done", s);
		end
		style <= 1'b0;
		repeat (6) @(posedge mclk);
		acc(1'b1, 8'h03, 8'h5a, lat);
		acc(1'b0, 8'h03, 8'h00, lat_r);
		acc(1'b1, 8'h03, 8'ha5, lat);
		repeat (12) @(posedge mclk);
		acc(1'b1, 8'h03, 8'h3c, lat2);
		`CHK(lat > lat2, 1'b1)
		`CHK(lat2, lat_r)
		$display("wait state test done");
		acc(1'b1, 8'h10, 8'h01, lat);
		set_st(8'h02);
		repeat (4) @(posedge mclk);
		`CHK(irq_oe, 1'b0)
		acc(1'b0, 8'h11, 8'h00, lat);
		set_st(8'h03);
		repeat (3) @(posedge mclk);
		`CHK(irq_oe, 1'b1)
		repeat (10) @(posedge mclk);
		`CHK(irq_oe ? irq_n : 1'b1, 1'b0)
		acc(1'b0, 8'h12, 8'h00, lat);
		acc(1'b0, 8'h11, 8'h00, lat);
		repeat (2) @(posedge mclk);
		`CHK(irq_oe, 1'b0)
		$display("interrupt test done");
		smode <= 1'b1;
		repeat (6) @(posedge mclk);
		for (int e = 0; e < 2; e++) begin
			esel <= e[0];
			a = 8'($urandom_range(0, 15));
			d = 8'($urandom);
			host.ser(1'b1, e[0], a[5:0], d, q, oe);
			`CHK(oe, 1'b0)
			host.ser(1'b0, e[0], a[5:0], 8'h00, q, oe);
			`CHK(q, d)
			$display("serial edge %0d done", e);
		end
		complete_run();
	end
endmodule
